// File: irq_priority_ctrl_0_map.vh
// Offsets, field positions and reset values of the priority control register.
// Assumes a 16-bit register word on a plain strobe port with one-cycle read latency.
//
// Behaviour
// - Compare channel 1 priority is a read/write 3-bit field at bits 10 to 8.
// - Priority code zero disables the source; codes 1 to 7 raise priority, 7 highest.
// - Capture channel 1 priority is a read/write 3-bit field at bits 6 to 4.
// - External pin 0 priority is a read/write 3-bit field at bits 2 to 0.
`ifndef IRQ_PRIORITY_CTRL_0_MAP_VH
`define IRQ_PRIORITY_CTRL_0_MAP_VH

// ****************************************************************
// Register offset
// ****************************************************************
`define PRIORITY_CONTROL_0_OFFSET 8'h00

// ****************************************************************
// Field positions (low bit of each 3-bit field)
// ****************************************************************
`define TIMER1_LEVEL_LSB   12
`define COMPARE1_LEVEL_LSB 8
`define CAPTURE1_LEVEL_LSB 4
`define EXT_PIN0_LEVEL_LSB 0
`define LEVEL_WIDTH        3

// ****************************************************************
// Reset values
// ****************************************************************
`define LEVEL_RESET        3'h4
`define READ_IDLE          16'h0000

`endif

// File: prio_level_field.v
// One 3-bit priority level field with its reset value and enable decode.
// Assumes the parent decodes the write and hands over the field's bits.
`timescale 1ns/1ps
module prio_level_field #(
    parameter WIDTH       = 3,
    parameter [WIDTH-1:0] RESET_VALUE = 3'h4
) (
    input  wire             clock_in,
    input  wire             resetn_in,
    input  wire             ce_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] data_in,
    output reg  [WIDTH-1:0] level_out,
    output wire             enabled_out
);

    // ****************************************************************
    // Level decode
    // ****************************************************************
    function level_enabled;
        input [WIDTH-1:0] level;
        begin
            level_enabled = (level != {WIDTH{1'b0}});
        end
    endfunction

    // ****************************************************************
    // Storage
    // ****************************************************************
    always @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            level_out <= RESET_VALUE;
        end
        else if (ce_in && load_in)
        begin
            level_out <= data_in;
        end
    end

    assign enabled_out = level_enabled(level_out);

endmodule

// File: irq_priority_ctrl_0.v
// Priority control register 0: four 3-bit source priority levels.
// Assumes a master that never strobes read and write together.
`timescale 1ns/1ps
`include "irq_priority_ctrl_0_map.vh"
module irq_priority_ctrl_0 #(
    parameter ADDR_WIDTH = 8
) (
    input  wire                  clock_in,
    input  wire                  resetn_in,
    input  wire                  ce_in,
    input  wire [ADDR_WIDTH-1:0] addr_in,
    input  wire [15:0]           wdata_in,
    input  wire                  write_in,
    input  wire                  read_in,
    output reg  [15:0]           rdata_out,
    output wire [2:0]            timer1_irq_level_out,
    output wire [2:0]            compare1_irq_level_out,
    output wire [2:0]            capture1_irq_level_out,
    output wire [2:0]            ext_pin0_irq_level_out,
    output wire                  timer1_irq_enabled_out,
    output wire                  compare1_irq_enabled_out,
    output wire                  capture1_irq_enabled_out,
    output wire                  ext_pin0_irq_enabled_out
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire                  hit;
    wire                  load;
    wire                  write_taken;
    wire                  read_taken;
    wire [15:0]           masked_wdata;
    wire [2:0]            timer1_wdata;
    wire [2:0]            compare1_wdata;
    wire [2:0]            capture1_wdata;
    wire [2:0]            ext_pin0_wdata;
    wire [15:0]           reg_value;
    reg  [15:0]           next_rdata;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // One offset is mapped; every other address reads zero and drops writes
    function addr_match;
        input [ADDR_WIDTH-1:0] addr;
        begin
            addr_match = (addr == `PRIORITY_CONTROL_0_OFFSET);
        end
    endfunction

    // Gap bits hold no storage, so they are forced low on both paths
    function [15:0] gap_clear;
        input [15:0] word;
        begin
            gap_clear                                     = word;
            gap_clear[`TIMER1_LEVEL_LSB + `LEVEL_WIDTH]   = 1'b0;
            gap_clear[`COMPARE1_LEVEL_LSB + `LEVEL_WIDTH] = 1'b0;
            gap_clear[`CAPTURE1_LEVEL_LSB + `LEVEL_WIDTH] = 1'b0;
            gap_clear[`EXT_PIN0_LEVEL_LSB + `LEVEL_WIDTH] = 1'b0;
        end
    endfunction

    function [`LEVEL_WIDTH-1:0] field_of;
        input [15:0]  word;
        input integer lsb;
        begin
            field_of = word[lsb +: `LEVEL_WIDTH];
        end
    endfunction

    function [15:0] pack_levels;
        input [`LEVEL_WIDTH-1:0] timer1;
        input [`LEVEL_WIDTH-1:0] compare1;
        input [`LEVEL_WIDTH-1:0] capture1;
        input [`LEVEL_WIDTH-1:0] ext_pin0;
        begin
            pack_levels                                      = `READ_IDLE;
            pack_levels[`TIMER1_LEVEL_LSB +: `LEVEL_WIDTH]   = timer1;
            pack_levels[`COMPARE1_LEVEL_LSB +: `LEVEL_WIDTH] = compare1;
            pack_levels[`CAPTURE1_LEVEL_LSB +: `LEVEL_WIDTH] = capture1;
            pack_levels[`EXT_PIN0_LEVEL_LSB +: `LEVEL_WIDTH] = ext_pin0;
        end
    endfunction

    // ****************************************************************
    // Strobe qualification
    // ****************************************************************
    // Strobes on a frozen edge are lost; the master must keep ce_in high
    assign hit         = addr_match(addr_in);
    assign write_taken = ce_in && write_in && hit;
    assign read_taken  = ce_in && read_in && hit;
    assign load        = write_taken;

    // ****************************************************************
    // Write data split
    // ****************************************************************
    assign masked_wdata   = gap_clear(wdata_in);
    assign timer1_wdata   = field_of(masked_wdata, `TIMER1_LEVEL_LSB);
    assign compare1_wdata = field_of(masked_wdata, `COMPARE1_LEVEL_LSB);
    assign capture1_wdata = field_of(masked_wdata, `CAPTURE1_LEVEL_LSB);
    assign ext_pin0_wdata = field_of(masked_wdata, `EXT_PIN0_LEVEL_LSB);

    // ****************************************************************
    // Priority fields
    // ****************************************************************
    prio_level_field #(
        .WIDTH       (`LEVEL_WIDTH),
        .RESET_VALUE (`LEVEL_RESET)
    ) u_timer1 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .load_in     (load),
        .data_in     (timer1_wdata),
        .level_out   (timer1_irq_level_out),
        .enabled_out (timer1_irq_enabled_out)
    );

    prio_level_field #(
        .WIDTH       (`LEVEL_WIDTH),
        .RESET_VALUE (`LEVEL_RESET)
    ) u_compare1 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .load_in     (load),
        .data_in     (compare1_wdata),
        .level_out   (compare1_irq_level_out),
        .enabled_out (compare1_irq_enabled_out)
    );

    prio_level_field #(
        .WIDTH       (`LEVEL_WIDTH),
        .RESET_VALUE (`LEVEL_RESET)
    ) u_capture1 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .load_in     (load),
        .data_in     (capture1_wdata),
        .level_out   (capture1_irq_level_out),
        .enabled_out (capture1_irq_enabled_out)
    );

    prio_level_field #(
        .WIDTH       (`LEVEL_WIDTH),
        .RESET_VALUE (`LEVEL_RESET)
    ) u_ext_pin0 (
        .clock_in    (clock_in),
        .resetn_in   (resetn_in),
        .ce_in       (ce_in),
        .load_in     (load),
        .data_in     (ext_pin0_wdata),
        .level_out   (ext_pin0_irq_level_out),
        .enabled_out (ext_pin0_irq_enabled_out)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Gap bits are constant zero, so written values there are simply dropped
    assign reg_value = gap_clear(pack_levels(timer1_irq_level_out,
                                             compare1_irq_level_out,
                                             capture1_irq_level_out,
                                             ext_pin0_irq_level_out));

    always @*
    begin
        next_rdata = `READ_IDLE;
        if (read_taken)
        begin
            next_rdata = reg_value;
        end
    end

    // Data stand in the cycle after a read and hold while ce_in is low; idle and unmapped reads with ce_in high give zero
    always @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            rdata_out <= `READ_IDLE;
        end
        else if (ce_in)
        begin
            rdata_out <= next_rdata;
        end
    end

endmodule

// File: irq_priority_ctrl_0_monitor.sv
// Checker on the priority control register port and level outputs.
// Assumes a bind into irq_priority_ctrl_0, with ADDR_WIDTH handed on.
`timescale 1ns/1ps
module irq_priority_ctrl_0_monitor #(
    parameter ADDR_WIDTH = 8
) (
    input wire                  clock_in,
    input wire                  resetn_in,
    input wire                  ce_in,
    input wire [ADDR_WIDTH-1:0] addr_in,
    input wire [15:0]           wdata_in,
    input wire                  write_in,
    input wire                  read_in,
    input wire [15:0]           rdata_out,
    input wire [2:0]            compare1_irq_level_out,
    input wire [2:0]            capture1_irq_level_out,
    input wire [2:0]            ext_pin0_irq_level_out,
    input wire                  compare1_irq_enabled_out
);
    // ****
    // Relations
    // ****
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_write;
        ce_in && write_in && ~|addr_in;
    endsequence
    sequence s_read;
        ce_in && read_in && ~|addr_in;
    endsequence
    chk_compare_write: assert property (
        s_write |=> compare1_irq_level_out == $past(wdata_in[10:8]))
        else $error("compare level not loaded");
    chk_capture_write: assert property (
        s_write |=> capture1_irq_level_out == $past(wdata_in[6:4]))
        else $error("capture level not loaded");
    chk_ext_write: assert property (
        s_write |=> ext_pin0_irq_level_out == $past(wdata_in[2:0]))
        else $error("pin level not loaded");
    chk_zero_disable: assert property (
        compare1_irq_enabled_out == (compare1_irq_level_out != 3'h0))
        else $error("enable does not follow level");
    // Unused bits must read zero even when the fields are all ones
    chk_gap_bits: assert property (
        s_read |=> (rdata_out & 16'h8888) == 16'h0000)
        else $error("unused bits read nonzero");
    chk_read_word: assert property (
        s_read |=> rdata_out[10:0] == {compare1_irq_level_out, 1'b0,
            capture1_irq_level_out, 1'b0, ext_pin0_irq_level_out})
        else $error("read word differs from levels");
    // A frozen edge must leave the compare, capture and pin levels and the read data alone
    chk_ce_freeze: assert property (
        !ce_in |=> $stable(compare1_irq_level_out) && $stable(capture1_irq_level_out)
            && $stable(ext_pin0_irq_level_out) && $stable(rdata_out))
        else $error("state moved while clock enable low");
    chk_idle_zero: assert property (
        ce_in && !(read_in && ~|addr_in) |=> rdata_out == 16'h0000)
        else $error("read data nonzero outside a read");
endmodule
bind irq_priority_ctrl_0 irq_priority_ctrl_0_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) mon_u (.*);

// File: tb_irq_priority_ctrl_0.sv
// Bench: table of writes and readbacks, then reset and unmapped cases.
// Assumes offset 8'h00 and one-cycle read latency; clock enable toggled once.
`timescale 1ns/1ps
module tb_irq_priority_ctrl_0;
    // ****
    // Stimulus
    // ****
    reg         clock_in  = 0;
    reg         resetn_in = 0;
    reg  [7:0]  addr_in   = 8'h00;
    reg  [15:0] wdata_in  = 16'h0000;
    reg         write_in  = 0;
    reg         read_in   = 0;
    reg         ce_in     = 1;
    wire [15:0] rdata_out;
    wire [2:0]  lt, lc, lp, le;
    wire [3:0]  en;
    reg  [15:0] q;
    reg  [15:0] e;
    reg  [31:0] rows [0:3];
    integer     error_cnt = 0;
    integer     cmp_count = 0;
    integer     i;
    irq_priority_ctrl_0 dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .timer1_irq_level_out(lt), .compare1_irq_level_out(lc),
        .capture1_irq_level_out(lp), .ext_pin0_irq_level_out(le),
        .timer1_irq_enabled_out(en[3]), .compare1_irq_enabled_out(en[2]),
        .capture1_irq_enabled_out(en[1]), .ext_pin0_irq_enabled_out(en[0]));
    initial
    begin
        forever #50 clock_in = ~clock_in;
    end
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp)
            begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clock_in);
            {write_in, addr_in, wdata_in} <= {1'b1, a, d};
            @(posedge clock_in);
            write_in <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe, so sample there
    task rd(input [7:0] a);
        begin
            @(posedge clock_in);
            {read_in, addr_in} <= {1'b1, a};
            @(posedge clock_in);
            read_in <= 1'b0;
            @(negedge clock_in);
            q = rdata_out;
        end
    endtask
    task summarize;
        begin
            if (error_cnt == 0 && cmp_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        summarize;
    end
    initial
    begin
        rows[0] = 32'hFFFF_7777;
        rows[1] = 32'h0000_0000;
        rows[2] = 32'h7531_7531;
        rows[3] = 32'h2A6C_2264;
        repeat (8) @(posedge clock_in);
        resetn_in <= 1'b1;
        rd(8'h00);
        chk(q, 16'h4444);
        chk({12'h000, en}, 16'h000F);
        for (i = 0; i < 4; i = i + 1)
        begin
            e = rows[i][15:0];
            wr(8'h00, rows[i][31:16]);
            rd(8'h00);
            chk(q, e);
            chk({1'b0, lt, 1'b0, lc, 1'b0, lp, 1'b0, le}, e);
            chk({12'h000, en}, {12'h000, |e[14:12], |e[10:8], |e[6:4], |e[2:0]});
        end
        wr(8'h01, 16'h1111);
        rd(8'h01);
        chk(q, 16'h0000);
        rd(8'h00);
        chk(q, 16'h2264);
        // A write on a frozen edge must be lost
        @(posedge clock_in);
        ce_in <= 1'b0;
        wr(8'h00, 16'h7777);
        @(posedge clock_in);
        ce_in <= 1'b1;
        rd(8'h00);
        chk(q, 16'h2264);
        chk({1'b0, lt, 1'b0, lc, 1'b0, lp, 1'b0, le}, 16'h2264);
        @(posedge clock_in);
        resetn_in <= 1'b0;
        @(posedge clock_in);
        resetn_in <= 1'b1;
        rd(8'h00);
        chk(q, 16'h4444);
        summarize;
    end
endmodule
